// file: verilog/pcdl_pkg.sv
// package of constants and types for pc card data lane steering
`default_nettype none
package pcdl_pkg;
	// register addresses on the control bus
	localparam logic [31:0] BUS_CONFIG_ONE_ADDR = 32'hffffff60;
	localparam logic [31:0] BUS_CONFIG_TWO_ADDR = 32'hfffff62;
	localparam logic [15:0] BUS_CONFIG_ONE_RST  = 16'h0000;
	localparam logic [15:0] BUS_CONFIG_TWO_RST  = 16'h0000;
	// field positions
	localparam int          MEM_WIDE_BIT        = 0;  // bus_config_one: memory card is 16 bit
	localparam int          IO_WIDE_BIT         = 1;  // bus_config_one: io card is 16 bit
	localparam int          PORT_SEL_BIT        = 0;  // bus_config_two: upper_lane_port_select
	localparam logic [15:0] BUS_CONFIG_ONE_MASK = 16'h0003;
	localparam logic [15:0] BUS_CONFIG_TWO_MASK = 16'h0001;
	// register access sizes
	localparam logic [1:0]  ACC_BYTE            = 2'h0;
	localparam logic [1:0]  ACC_WORD            = 2'h1;
	localparam logic [1:0]  ACC_LONG            = 2'h2;
	// top lanes driven when the port is selected (bits 31 and 30)
	localparam logic [7:0]  TOP_LANE_OE         = 8'hc0;
	localparam int          WAIT_W              = 3;
	localparam logic [WAIT_W-1:0] WAIT_ZERO     = 3'h0;
	// card cycle states
	typedef enum logic [3:0] {
		PCDL_IDLE    = 4'h1,
		PCDL_ACTIVE  = 4'h2,
		PCDL_STRETCH = 4'h4,
		PCDL_FINISH  = 4'h8
	} pcdl_state_t;
endpackage : pcdl_pkg
`default_nettype wire

// file: verilog/pcdl_lane.sv
// one registered byte lane group with its output enables
`default_nettype none
module pcdl_lane #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] drive_en,
	input  wire logic [WIDTH-1:0] drive_data,
	output logic      [WIDTH-1:0] pin_out,
	output logic      [WIDTH-1:0] pin_oe
);
	typedef struct packed {
		logic [WIDTH-1:0] data;
		logic [WIDTH-1:0] oe;
	} pcdl_lane_t;

	pcdl_lane_t lane_reg;
	pcdl_lane_t lane_next;

	// next lane value follows the request
	always_comb begin
		lane_next      = lane_reg;
		lane_next.data = drive_data;
		lane_next.oe   = drive_en;
	end

	// lanes released to high impedance in reset
	always_ff @(posedge clk) begin
		if (rst) begin
			lane_reg <= '0;
		end else begin
			lane_reg <= lane_next;
		end
	end

	assign pin_out = lane_reg.data;
	assign pin_oe  = lane_reg.oe;
endmodule : pcdl_lane
`default_nettype wire

// file: verilog/pcdl_steer.sv
// pc card data lane steering top: bus config registers, card cycle, lanes
//
// Summary of operation
// - eight bit card: all transfers on lanes 7..0, lanes 15..8 high impedance.
// - sixteen bit card: byte reads take even from 15..8, odd from 7..0; byte writes and words use both.
// - lanes 23..16 high impedance unless port selected, then follow port settings.
// - lanes 31..24 high impedance unless port selected, then only 31,30 drive.
// - wait input ignored when wait count is zero, sampled otherwise.
`default_nettype none
module pcdl_steer (
	input  wire logic                       clk,
	input  wire logic                       rst,
	// control register port
	input  wire logic                       reg_sel,
	input  wire logic                       reg_write,
	input  wire logic [31:0]                reg_addr,
	input  wire logic [1:0]                 reg_size,
	input  wire logic [15:0]                reg_wdata,
	output logic      [15:0]                reg_rdata,
	// card access from the core
	input  wire logic                       acc_start,
	input  wire logic                       acc_write,
	input  wire logic                       acc_io,
	input  wire logic                       acc_odd,
	input  wire logic [1:0]                 acc_size,
	input  wire logic [15:0]                acc_wdata,
	input  wire logic [pcdl_pkg::WAIT_W-1:0] acc_wait_cfg,
	output logic                            acc_busy,
	output logic                            acc_done,
	output logic      [15:0]                acc_rdata,
	// port settings for the upper lanes
	input  wire logic [7:0]                 port_dir,
	input  wire logic [7:0]                 port_data,
	input  wire logic [1:0]                 port_top_data,
	// card pins
	input  wire logic                       card_wait_n,
	input  wire logic [31:0]                data_in,
	output logic      [31:0]                data_out,
	output logic      [31:0]                data_oe,
	output logic                            upper_lane_port_select
);
	typedef struct packed {
		pcdl_pkg::pcdl_state_t       state;
		logic [pcdl_pkg::WAIT_W-1:0] count;
		logic [pcdl_pkg::WAIT_W-1:0] wait_cfg;
		logic                        write;
		logic                        io;
		logic                        odd;
		logic [1:0]                  size;
		logic [15:0]                 wdata;
		logic [15:0]                 rdata;
		logic                        done;
		logic [15:0]                 cfg_one;
		logic [15:0]                 cfg_two;
		logic [15:0]                 reg_rd;
	} pcdl_state_rec_t;

	pcdl_state_rec_t st_reg;
	pcdl_state_rec_t st_next;

	logic        wide;
	logic        in_cycle;
	logic        hit_one;
	logic        hit_two;
	logic        size_ok;
	logic        port_on;
	logic [7:0]  lo_en;
	logic [7:0]  hi_en;
	logic [7:0]  lo_dat;
	logic [7:0]  hi_dat;
	logic [7:0]  u_en;
	logic [7:0]  u_dat;
	logic [7:0]  t_en;
	logic [7:0]  t_dat;
	logic [15:0] sample;

	// register decode
	assign hit_one = reg_sel && (reg_addr == pcdl_pkg::BUS_CONFIG_ONE_ADDR);
	assign hit_two = reg_sel && (reg_addr == pcdl_pkg::BUS_CONFIG_TWO_ADDR);
	assign size_ok = (reg_size == pcdl_pkg::ACC_WORD);

	// width of the card in the current area
	assign wide     = st_reg.io ? st_reg.cfg_one[pcdl_pkg::IO_WIDE_BIT]
	                            : st_reg.cfg_one[pcdl_pkg::MEM_WIDE_BIT];
	assign in_cycle = (st_reg.state == pcdl_pkg::PCDL_ACTIVE) ||
	                  (st_reg.state == pcdl_pkg::PCDL_STRETCH);
	assign port_on  = st_reg.cfg_two[pcdl_pkg::PORT_SEL_BIT];

	// lanes 15..0 for writes
	always_comb begin
		lo_en  = 8'h00;
		hi_en  = 8'h00;
		lo_dat = 8'h00;
		hi_dat = 8'h00;
		if (in_cycle && st_reg.write) begin
			if (!wide) begin
				lo_en  = 8'hff;
				lo_dat = st_reg.wdata[7:0];
			end else if (st_reg.size == pcdl_pkg::ACC_BYTE) begin
				lo_en  = 8'hff;
				hi_en  = 8'hff;
				lo_dat = st_reg.wdata[7:0];
				hi_dat = st_reg.wdata[7:0];
			end else begin
				lo_en  = 8'hff;
				hi_en  = 8'hff;
				lo_dat = st_reg.wdata[7:0];
				hi_dat = st_reg.wdata[15:8];
			end
		end
	end

	// upper lanes: port or high impedance
	always_comb begin
		u_en  = 8'h00;
		u_dat = 8'h00;
		t_en  = 8'h00;
		t_dat = 8'h00;
		if (port_on) begin
			u_en  = port_dir;
			u_dat = port_data;
			t_en  = pcdl_pkg::TOP_LANE_OE;
			t_dat = {port_top_data, 6'h00};
		end
	end

	// read data gathered from the valid lanes
	always_comb begin
		sample = 16'h0000;
		if (!wide) begin
			sample = {8'h00, data_in[7:0]};
		end else if (st_reg.size != pcdl_pkg::ACC_BYTE) begin
			sample = data_in[15:0];
		end else if (st_reg.odd) begin
			sample = {8'h00, data_in[7:0]};
		end else begin
			sample = {8'h00, data_in[15:8]};
		end
	end

	// next state of registers and card cycle
	always_comb begin
		st_next      = st_reg;
		st_next.done = 1'b0;
		st_next.reg_rd = 16'h0000;
		if (reg_sel && !reg_write && size_ok) begin
			if (hit_one) begin
				st_next.reg_rd = st_reg.cfg_one;
			end else if (hit_two) begin
				st_next.reg_rd = st_reg.cfg_two;
			end
		end
		if (reg_sel && reg_write && size_ok) begin
			if (hit_one) begin
				st_next.cfg_one = reg_wdata & pcdl_pkg::BUS_CONFIG_ONE_MASK;
			end else if (hit_two) begin
				st_next.cfg_two = reg_wdata & pcdl_pkg::BUS_CONFIG_TWO_MASK;
			end
		end
		case (st_reg.state)
			pcdl_pkg::PCDL_IDLE: begin
				if (acc_start) begin
					st_next.state    = pcdl_pkg::PCDL_ACTIVE;
					st_next.count    = acc_wait_cfg;
					st_next.wait_cfg = acc_wait_cfg;
					st_next.write    = acc_write;
					st_next.io       = acc_io;
					st_next.odd      = acc_odd;
					st_next.size     = acc_size;
					st_next.wdata    = acc_wdata;
				end
			end
			pcdl_pkg::PCDL_ACTIVE: begin
				if (st_reg.count != pcdl_pkg::WAIT_ZERO) begin
					st_next.count = st_reg.count - 3'h1;
				end else if ((st_reg.wait_cfg != pcdl_pkg::WAIT_ZERO) && !card_wait_n) begin
					st_next.state = pcdl_pkg::PCDL_STRETCH;
				end else begin
					st_next.state = pcdl_pkg::PCDL_FINISH;
				end
			end
			pcdl_pkg::PCDL_STRETCH: begin
				if (card_wait_n) begin
					st_next.state = pcdl_pkg::PCDL_FINISH;
				end
			end
			pcdl_pkg::PCDL_FINISH: begin
				if (!st_reg.write) begin
					st_next.rdata = sample;
				end
				st_next.done  = 1'b1;
				st_next.state = pcdl_pkg::PCDL_IDLE;
			end
			default: begin
				st_next.state = pcdl_pkg::PCDL_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg         <= '0;
			st_reg.state   <= pcdl_pkg::PCDL_IDLE;
			st_reg.cfg_one <= pcdl_pkg::BUS_CONFIG_ONE_RST;
			st_reg.cfg_two <= pcdl_pkg::BUS_CONFIG_TWO_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// lane drivers, one per byte lane
	pcdl_lane #(.WIDTH(8)) u_lane0 (
		.clk        (clk),
		.rst        (rst),
		.drive_en   (lo_en),
		.drive_data (lo_dat),
		.pin_out    (data_out[7:0]),
		.pin_oe     (data_oe[7:0])
	);
	pcdl_lane #(.WIDTH(8)) u_lane1 (
		.clk        (clk),
		.rst        (rst),
		.drive_en   (hi_en),
		.drive_data (hi_dat),
		.pin_out    (data_out[15:8]),
		.pin_oe     (data_oe[15:8])
	);
	pcdl_lane #(.WIDTH(8)) u_lane2 (
		.clk        (clk),
		.rst        (rst),
		.drive_en   (u_en),
		.drive_data (u_dat),
		.pin_out    (data_out[23:16]),
		.pin_oe     (data_oe[23:16])
	);
	pcdl_lane #(.WIDTH(8)) u_lane3 (
		.clk        (clk),
		.rst        (rst),
		.drive_en   (t_en),
		.drive_data (t_dat),
		.pin_out    (data_out[31:24]),
		.pin_oe     (data_oe[31:24])
	);

	assign reg_rdata              = st_reg.reg_rd;
	assign acc_busy               = (st_reg.state != pcdl_pkg::PCDL_IDLE);
	assign acc_done               = st_reg.done;
	assign acc_rdata              = st_reg.rdata;
	assign upper_lane_port_select = port_on;
endmodule : pcdl_steer
`default_nettype wire

// file: testbench/pcdl_steer_asserts.sv
// port assertions for the lane steering top
`default_nettype none
module pcdl_steer_asserts (
	input wire logic                        clk,
	input wire logic                        rst,
	input wire logic                        acc_start,
	input wire logic                        acc_busy,
	input wire logic                        acc_done,
	input wire logic [pcdl_pkg::WAIT_W-1:0] acc_wait_cfg,
	input wire logic                        card_wait_n,
	input wire logic [7:0]                  port_dir,
	input wire logic [31:0]                 data_oe,
	input wire logic                        upper_lane_port_select
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	chk_upper_hiz: assert property (
		!upper_lane_port_select && !$past(upper_lane_port_select) |-> data_oe[23:16] == 8'h00)
		else $error("upper lanes driven with port off");
	chk_top_hiz: assert property (
		!upper_lane_port_select && !$past(upper_lane_port_select) |-> data_oe[31:24] == 8'h00)
		else $error("top lanes driven with port off");
	chk_port_follow: assert property (
		upper_lane_port_select && $past(upper_lane_port_select)
		|-> data_oe[23:16] == $past(port_dir)) else $error("port lanes ignore direction");
	chk_top_pair: assert property (
		upper_lane_port_select && $past(upper_lane_port_select) |-> data_oe[31:24] == 8'hc0)
		else $error("top lanes not just bits 31 and 30");
	chk_lane_pair: assert property (
		data_oe[15:8] != 8'h00 |-> data_oe[15:0] == 16'hffff)
		else $error("high lane driven without low lane");
	chk_lane_cycle: assert property (
		data_oe[15:0] != 16'h0000 |-> $past(acc_busy)) else $error("lanes driven outside cycle");
	chk_wait_off: assert property (
		acc_start && !acc_busy && acc_wait_cfg == 3'h0 |-> ##3 acc_done)
		else $error("zero wait cycle not done in three");
	chk_wait_on: assert property (
		acc_start && !acc_busy && acc_wait_cfg == 3'h1 && !card_wait_n ##1 (!card_wait_n)[*4]
		|-> !acc_done) else $error("wait input not honoured");
endmodule : pcdl_steer_asserts
bind pcdl_steer pcdl_steer_asserts u_chk (.clk(clk), .rst(rst), .acc_start(acc_start),
	.acc_busy(acc_busy), .acc_done(acc_done), .acc_wait_cfg(acc_wait_cfg),
	.card_wait_n(card_wait_n), .port_dir(port_dir), .data_oe(data_oe),
	.upper_lane_port_select(upper_lane_port_select));
`default_nettype wire

// file: testbench/pcdl_card_model.sv
// behavioural card on the far side of the data lanes
`default_nettype none
module pcdl_card_model (
	input  wire logic        clk,
	input  wire logic        drive,
	input  wire logic        hold_wait,
	input  wire logic [15:0] rd_word,
	input  wire logic [31:0] data_out,
	input  wire logic [31:0] data_oe,
	output logic      [31:0] data_in,
	output logic             card_wait_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] junk_reg = 32'h0;
	// undriven lines toggle so stale data never looks valid
	always_ff @(posedge clk) begin
		junk_reg <= ~junk_reg;
	end
	// wire level from device drive, card drive or junk
	always_comb begin
		data_in = (data_oe & data_out) | (~data_oe & junk_reg);
		if (drive) begin
			data_in[15:0] = rd_word;
		end
		card_wait_n = !hold_wait;
	end
endmodule : pcdl_card_model
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the lane steering top
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rst = 1'b1, reg_sel = 1'b0, reg_write = 1'b0, hold_wait = 1'b0;
	logic        acc_start = 1'b0, acc_write = 1'b0, acc_io = 1'b0, acc_odd = 1'b0, drive;
	logic        acc_busy, acc_done, card_wait_n, upper_lane_port_select;
	logic [31:0] reg_addr = 32'h0, data_in, data_out, data_oe, seen_oe, seen_out;
	logic [1:0]  reg_size = 2'h0, acc_size = 2'h0, port_top_data = 2'h0;
	logic [15:0] reg_wdata = 16'h0, acc_wdata = 16'h0, reg_rdata, acc_rdata;
	logic [15:0] wm[3] = '{16'hff00, 16'h00ff, 16'hffff}, wv[3] = '{16'h5100, 16'h0051, 16'h3c51};
	logic [15:0] rm[3] = '{16'h00ff, 16'h00ff, 16'hffff}, rv[3] = '{16'h0012, 16'h00c3, 16'h12c3};
	logic [7:0]  port_dir = 8'h0, port_data = 8'h0;
	logic [pcdl_pkg::WAIT_W-1:0] acc_wait_cfg = 3'h0;
	int          miscompares = 0, total_checks = 0, cycles, m, k;
	always #4 clk = ~clk;
	// card answers only while a read cycle runs
	assign drive = acc_busy && !acc_write;
	pcdl_steer DUT (.clk, .rst, .reg_sel, .reg_write, .reg_addr, .reg_size, .reg_wdata,
		.reg_rdata, .acc_start, .acc_write, .acc_io, .acc_odd, .acc_size, .acc_wdata,
		.acc_wait_cfg, .acc_busy, .acc_done, .acc_rdata, .port_dir, .port_data, .port_top_data,
		.card_wait_n, .data_in, .data_out, .data_oe, .upper_lane_port_select);
	pcdl_card_model u_card (.clk, .drive, .hold_wait, .rd_word(16'h12c3), .data_out, .data_oe,
		.data_in, .card_wait_n);
	task automatic wrap_up;
		if (miscompares == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic reg_op(input logic wr, input logic [31:0] a, input logic [1:0] sz,
		input logic [15:0] d);
		@(posedge clk);
		reg_sel <= 1'b1;
		reg_write <= wr;
		reg_addr <= a;
		reg_size <= sz;
		reg_wdata <= d;
		@(posedge clk);
		reg_sel <= 1'b0;
		#1;
	endtask : reg_op
	task automatic reg_rd(input logic [31:0] a, input logic [15:0] exp);
		reg_op(1'b0, a, pcdl_pkg::ACC_WORD, 16'h0);
		chk(32'(reg_rdata), 32'(exp));
	endtask : reg_rd
	task automatic acc(input logic wr, io, odd, input logic [1:0] sz, input logic [2:0] n);
		@(posedge clk);
		acc_start <= 1'b1;
		acc_write <= wr;
		acc_io <= io;
		acc_odd <= odd;
		acc_size <= sz;
		acc_wdata <= 16'h3c51;
		acc_wait_cfg <= n;
		@(posedge clk);
		acc_start <= 1'b0;
		seen_oe = 32'h0;
		seen_out = 32'h0;
		for (cycles = 1; cycles < 40; cycles++) begin
			#1;
			if (data_oe[15:0] !== 16'h0) begin
				seen_oe = data_oe;
				seen_out = data_out;
			end
			if (acc_done === 1'b1) break;
			@(posedge clk);
		end
		if (cycles == 40) begin
			miscompares++;
			$display("[ERR] %0t card cycle hung", $time);
			wrap_up();
		end
	endtask : acc
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		reg_rd(pcdl_pkg::BUS_CONFIG_TWO_ADDR, pcdl_pkg::BUS_CONFIG_TWO_RST);
		// refused byte write and unmapped place
		reg_op(1'b1, pcdl_pkg::BUS_CONFIG_ONE_ADDR, pcdl_pkg::ACC_BYTE, 16'h0003);
		reg_rd(pcdl_pkg::BUS_CONFIG_ONE_ADDR, 16'h0000);
		reg_op(1'b1, 32'hffffff64, pcdl_pkg::ACC_WORD, 16'hffff);
		reg_rd(32'hffffff64, 16'h0000);
		// both card widths, both areas, byte even, byte odd, word
		for (int w = 0; w < 2; w++) begin
			reg_op(1'b1, pcdl_pkg::BUS_CONFIG_ONE_ADDR, pcdl_pkg::ACC_WORD, w ? 16'hffff : 16'h0);
			reg_rd(pcdl_pkg::BUS_CONFIG_ONE_ADDR, w ? 16'h0003 : 16'h0000);
			for (int i = 0; i < 6; i++) begin
				m = i % 3;
				k = w ? m : 1;
				acc(1'b1, i > 2, m == 1, m == 2 ? pcdl_pkg::ACC_WORD : pcdl_pkg::ACC_BYTE, 3'h0);
				chk(seen_oe, w ? 32'h0000ffff : 32'h000000ff);
				if (w || m < 2) chk(32'(seen_out[15:0] & wm[k]), 32'(wv[k]));
				acc(1'b0, i > 2, m == 1, m == 2 ? pcdl_pkg::ACC_WORD : pcdl_pkg::ACC_BYTE, 3'h0);
				if (w || m < 2) chk(32'(acc_rdata & rm[k]), 32'(rv[k]));
			end
		end
		// refused long read gives zero
		reg_op(1'b0, pcdl_pkg::BUS_CONFIG_ONE_ADDR, pcdl_pkg::ACC_LONG, 16'h0);
		chk(32'(reg_rdata), 32'h0);
		// wait input ignored at zero count, honoured otherwise
		@(posedge clk);
		hold_wait <= 1'b1;
		acc(1'b1, 1'b0, 1'b0, pcdl_pkg::ACC_WORD, 3'h0);
		chk(cycles, 3);
		fork
			acc(1'b1, 1'b0, 1'b0, pcdl_pkg::ACC_WORD, 3'h1);
			begin
				repeat (6) @(posedge clk);
				hold_wait <= 1'b0;
			end
		join
		chk(cycles, 7);
		acc(1'b0, 1'b1, 1'b0, pcdl_pkg::ACC_WORD, 3'h2);
		chk(cycles, 5);
		// upper lanes reassigned as a port, then released
		@(posedge clk);
		port_dir <= 8'h5a;
		port_data <= 8'h3c;
		port_top_data <= 2'h2;
		reg_op(1'b1, pcdl_pkg::BUS_CONFIG_TWO_ADDR, pcdl_pkg::ACC_WORD, 16'h0001);
		acc(1'b1, 1'b1, 1'b1, pcdl_pkg::ACC_BYTE, 3'h0);
		chk(32'(upper_lane_port_select), 1);
		chk({data_oe[31:16], data_out[31:16]}, 32'hc05a803c);
		reg_op(1'b1, pcdl_pkg::BUS_CONFIG_TWO_ADDR, pcdl_pkg::ACC_WORD, 16'h0000);
		acc(1'b1, 1'b0, 1'b0, pcdl_pkg::ACC_BYTE, 3'h0);
		chk(32'(seen_oe[31:16]), 32'h0);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
